//--- tb/amd_decoder_checker.sv
// port-level assertions for the addressing-mode decoder
`timescale 1ns/100ps

module amd_decoder_checker
   import amd_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // request and memory side
   input wire logic i_start,
   input wire logic i_mem_ack,
   input wire logic o_mem_req,
   input wire logic [15:0] o_mem_addr,
   // status and result
   input wire logic o_busy,
   input wire logic o_done,
   input wire amd_pkg::amd_result_t o_result
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);

   // a refused decode is judged by the bench, not here
   wire done_ok = o_done && !o_result.illegal;

   a_done_one_pulse: assert property (o_done |=> !o_done)
      else $error("done lasted more than one cycle");
   a_start_gives_busy: assert property (i_start && !o_busy |=> o_busy)
      else $error("busy did not follow an accepted start");
   a_req_within_busy: assert property (o_mem_req |-> o_busy)
      else $error("memory request outside busy");
   a_addr_held_ack: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
      else $error("request dropped or address moved before ack");
   a_done_in_time: assert property ($rose(o_busy) |-> ##[2:40] o_done)
      else $error("decode did not finish in time");
   a_inherent_one_byte: assert property (
      done_ok && o_result.mode == AMD_M_INH |-> o_result.length == 3'd1 + 3'(o_result.use_y))
      else $error("inherent length wrong");
   a_immediate_two_bytes: assert property (
      done_ok && o_result.mode == AMD_M_IMM |-> o_result.length == 3'd2 + 3'(o_result.use_y))
      else $error("immediate length wrong");
   a_short_dir_page: assert property (
      done_ok && o_result.mode == AMD_M_DIR_S |-> o_result.ea[15:8] == 8'h00
      && o_result.length == 3'd2 + 3'(o_result.use_y))
      else $error("short direct left page zero or wrong length");
   a_long_dir_len: assert property (
      done_ok && o_result.mode == AMD_M_DIR_L |-> o_result.length == 3'd3 + 3'(o_result.use_y))
      else $error("long direct length wrong");
   a_rel_target_sum: assert property (
      done_ok && o_result.mode == AMD_M_REL_D
      |-> o_result.target == o_result.next_pc + {{8{o_result.operand[7]}}, o_result.operand})
      else $error("relative target wrong");
   a_idx_none_page: assert property (
      done_ok && o_result.mode == AMD_M_IDX_N |-> o_result.ea[15:8] == 8'h00
      && o_result.length == 3'd1 + 3'(o_result.use_y))
      else $error("no-offset indexed wrong");
   a_ind_short_page: assert property (
      done_ok && o_result.mode == AMD_M_IND_S |-> o_result.ea[15:8] == 8'h00
      && o_result.length == 3'd3)
      else $error("short indirect wrong");

   c_long_indirect: cover property (done_ok && o_result.mode == AMD_M_IND_L);
   c_stalled_fetch: cover property (o_mem_req && !i_mem_ack);
   c_refused_form: cover property (o_done && o_result.illegal);
endmodule : amd_decoder_checker

bind amd_decoder amd_decoder_checker #(.ADDR_W(ADDR_W)) u_amd_decoder_checker (
   .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_start(i_start), .i_mem_ack(i_mem_ack),
   .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_done(o_done),
   .o_result(o_result));

//--- tb/amd_decoder_tb_top.sv
// self-checking bench for the addressing-mode decoder
`timescale 1ns/100ps
`include "amd_params.svh"

module amd_decoder_tb_top;
   import amd_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_start = 1'b0;
   logic [15:0] i_pc = 16'h0000;
   logic [7:0] i_x = 8'h00;
   logic [7:0] i_y = 8'h00;
   logic slow = 1'b0;
   logic mem_req, mem_ack, busy, done;
   logic [15:0] mem_addr;
   logic [7:0] mem_rdata;
   amd_result_t res;
   int err_count = 0;
   int checks_done = 0;

   always #50 i_sys_clk = ~i_sys_clk;

   amd_decoder u_amd_decoder (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_start(i_start),
      .i_pc(i_pc), .i_x(i_x), .i_y(i_y), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
      .o_mem_req(mem_req), .o_mem_addr(mem_addr), .o_busy(busy), .o_done(done), .o_result(res));
   amd_mem_model u_amd_mem_model (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_req(mem_req),
      .i_addr(mem_addr), .i_slow(slow), .o_ack(mem_ack), .o_rdata(mem_rdata));

   // ------
   // shared tasks
   // ------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic chk_res(input logic [15:0] ea, input logic [2:0] len, input amd_mode_t m);
      chk(res.ea, ea);
      chk(16'(res.length), 16'(len));
      chk(16'(res.mode), 16'(m));
      chk(16'(res.illegal), 16'h0);
   endtask : chk_res

   // bytes go high first, as the core lays them out
   task automatic prog(input logic [15:0] a, input logic [31:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         u_amd_mem_model.mem[a + 16'(i)] = w[8 * (n - 1 - i) +: 8];
      end
   endtask : prog

   // cycle count equals bytes fetched plus two with a prompt memory
   task automatic decode(input logic [15:0] pc, input logic [7:0] x, y, output int cyc);
      @(negedge i_sys_clk);
      i_pc = pc;
      i_x = x;
      i_y = y;
      i_start = 1'b1;
      @(negedge i_sys_clk);
      i_start = 1'b0;
      cyc = 1;
      while (done !== 1'b1 && cyc < 60) begin
         @(negedge i_sys_clk);
         cyc++;
      end
      chk(16'(done), 16'h1);
   endtask : decode

   // ------
   // scenarios
   // ------
   task automatic t_inherent();
      logic [7:0] ops [12];
      amd_inh_t kinds [12];
      int c;
      ops = '{`AMD_OP_NOP, `AMD_OP_TRAP, `AMD_OP_WAIT, `AMD_OP_HALT, `AMD_OP_RET, `AMD_OP_IRET,
         `AMD_OP_SET_MASK, `AMD_OP_CLR_MASK, `AMD_OP_SET_CARRY, `AMD_OP_CLR_CARRY,
         `AMD_OP_SP_RESET, `AMD_OP_MUL};
      kinds = '{AMD_I_NOP, AMD_I_TRAP, AMD_I_WAIT, AMD_I_HALT, AMD_I_RET, AMD_I_IRET,
         AMD_I_SET_MASK, AMD_I_CLR_MASK, AMD_I_SET_CARRY, AMD_I_CLR_CARRY, AMD_I_SP_RESET,
         AMD_I_MUL};
      for (int i = 0; i < 12; i++) begin
         prog(16'h0100, 32'(ops[i]), 1);
         decode(16'h0100, 8'h00, 8'h00, c);
         chk(16'(res.inh), 16'(kinds[i]));
         chk_res(16'h0000, 3'd1, AMD_M_INH);
         chk(16'(c), 16'h3);
      end
   endtask : t_inherent

   task automatic t_imm_direct();
      int c1, c2;
      prog(16'h0180, 32'ha655, 2);
      decode(16'h0180, 8'h00, 8'h00, c1);
      chk_res(16'h0000, 3'd2, AMD_M_IMM);
      chk(16'(res.operand), 16'h55);
      prog(16'h0200, 32'hb6ff, 2);
      decode(16'h0200, 8'h00, 8'h00, c1);
      chk_res(16'h00ff, 3'd2, AMD_M_DIR_S);
      prog(16'h0210, 32'hc6ffff, 3);
      decode(16'h0210, 8'h00, 8'h00, c2);
      chk_res(16'hffff, 3'd3, AMD_M_DIR_L);
      chk(res.next_pc, 16'h0213);
      chk(16'(c2 - c1), 16'h1);
   endtask : t_imm_direct

   task automatic t_indexed();
      int c;
      prog(16'h0300, 32'hf6, 1);
      decode(16'h0300, 8'hff, 8'h00, c);
      chk_res(16'h00ff, 3'd1, AMD_M_IDX_N);
      prog(16'h0310, 32'h90f6, 2);
      decode(16'h0310, 8'h00, 8'h80, c);
      chk_res(16'h0080, 3'd2, AMD_M_IDX_N);
      chk(16'(res.use_y), 16'h1);
      prog(16'h0320, 32'he6ff, 2);
      decode(16'h0320, 8'hff, 8'h00, c);
      chk_res(16'h01fe, 3'd2, AMD_M_IDX_S);
      prog(16'h0330, 32'hd6fff0, 3);
      decode(16'h0330, 8'h20, 8'h00, c);
      chk_res(16'h0010, 3'd3, AMD_M_IDX_L);
   endtask : t_indexed

   task automatic t_indirect();
      int c;
      prog(16'h0400, 32'h92b620, 3);
      prog(16'h0020, 32'h34, 1);
      decode(16'h0400, 8'h00, 8'h00, c);
      chk_res(16'h0034, 3'd3, AMD_M_IND_S);
      prog(16'h0410, 32'h92c6ff, 3);
      prog(16'h00ff, 32'h12, 1);
      prog(16'h0000, 32'h34, 1);
      decode(16'h0410, 8'h00, 8'h00, c);
      chk_res(16'h1234, 3'd3, AMD_M_IND_L);
      prog(16'h0420, 32'h92e640, 3);
      prog(16'h0040, 32'hff, 1);
      decode(16'h0420, 8'hff, 8'h00, c);
      chk_res(16'h01fe, 3'd3, AMD_M_IND_IDX_S);
      prog(16'h0430, 32'h91e640, 3);
      decode(16'h0430, 8'h00, 8'h01, c);
      chk_res(16'h0100, 3'd3, AMD_M_IND_IDX_S);
   endtask : t_indirect

   task automatic t_relative();
      int c;
      prog(16'h1000, 32'h2080, 2);
      decode(16'h1000, 8'h00, 8'h00, c);
      chk_res(16'h0f82, 3'd2, AMD_M_REL_D);
      prog(16'h1010, 32'h207f, 2);
      decode(16'h1010, 8'h00, 8'h00, c);
      chk_res(16'h1091, 3'd2, AMD_M_REL_D);
      prog(16'h1030, 32'h922050, 3);
      prog(16'h0050, 32'hfe, 1);
      decode(16'h1030, 8'h00, 8'h00, c);
      chk_res(16'h1031, 3'd3, AMD_M_REL_I);
      prog(16'h1020, 32'h031005, 3);
      decode(16'h1020, 8'h00, 8'h00, c);
      chk_res(16'h0010, 3'd3, AMD_M_BIT_D_REL);
      chk(res.target, 16'h1028);
      chk({res.opcode, res.rmw, res.family, res.bit_pos, res.bit_clr}, 16'h03e3);
   endtask : t_relative

   task automatic t_rmw_illegal();
      int c;
      prog(16'h0500, 32'h3c10, 2);
      decode(16'h0500, 8'h00, 8'h00, c);
      chk(16'(res.rmw), 16'h1);
      prog(16'h0510, 32'hb610, 2);
      decode(16'h0510, 8'h00, 8'h00, c);
      chk(16'(res.rmw), 16'h0);
      prog(16'h0600, 32'h9090b6, 3);
      decode(16'h0600, 8'h00, 8'h00, c);
      chk(16'(res.illegal), 16'h1);
      chk(16'(c), 16'h4);
   endtask : t_rmw_illegal

   task automatic t_slow_refused();
      int c;
      prog(16'h2000, 32'hc61234, 3);
      @(negedge i_sys_clk);
      slow = 1'b1;
      i_pc = 16'h2000;
      i_start = 1'b1;
      @(negedge i_sys_clk);
      i_pc = 16'h2100;
      @(negedge i_sys_clk);
      i_start = 1'b0;
      c = 0;
      while (done !== 1'b1 && c < 60) begin
         @(negedge i_sys_clk);
         c++;
      end
      chk_res(16'h1234, 3'd3, AMD_M_DIR_L);
      chk(res.next_pc, 16'h2003);
      slow = 1'b0;
   endtask : t_slow_refused

   // ------
   // main sequence and watchdog
   // ------
   initial begin
      repeat (12) @(negedge i_sys_clk);
      i_rstn = 1'b1;
      t_inherent();
      t_imm_direct();
      t_indexed();
      t_indirect();
      t_relative();
      t_rmw_illegal();
      t_slow_refused();
      report_and_stop();
   end

   // the whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      err_count++;
      report_and_stop();
   end
endmodule : amd_decoder_tb_top

//--- tb/amd_mem_model.sv
// program and data memory seen by the decoder, prompt or slow
`timescale 1ns/100ps

module amd_mem_model (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // read port
   input wire logic i_req,
   input wire logic [15:0] i_addr,
   input wire logic i_slow,
   output logic o_ack,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:65535];
   logic [1:0] wait_q;
   logic [7:0] last_q;

   // slow mode stalls each byte two cycles
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn || !i_req || o_ack) begin
         wait_q <= 2'h0;
      end else begin
         wait_q <= wait_q + 2'h1;
      end
      last_q <= !i_rstn ? 8'h00 : (o_ack ? o_rdata : last_q);
   end
   assign o_ack = i_req && (!i_slow || wait_q == 2'h2);
   // data is not held after ack: a stale byte must not pass as good
   assign o_rdata = o_ack ? mem[i_addr] : ~last_q;
endmodule : amd_mem_model

//--- verilog/amd_decoder.sv
// addressing-mode decoder: fetches prefix, opcode and operand bytes, forms the address
`timescale 1ns/100ps
`include "amd_params.svh"

module amd_decoder #(
   parameter int ADDR_W = `AMD_ADDR_W
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // decode request from the core
   input wire logic i_start,
   input wire logic [15:0] i_pc,
   input wire logic [7:0] i_x,
   input wire logic [7:0] i_y,
   // memory read port
   input wire logic i_mem_ack,
   input wire logic [7:0] i_mem_rdata,
   output logic o_mem_req,
   output logic [15:0] o_mem_addr,
   // decode result
   output logic o_busy,
   output logic o_done,
   output amd_pkg::amd_result_t o_result
);
   import amd_pkg::*;

   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   if (ADDR_W != `AMD_ADDR_W) begin : g_bad_width
      $error("address width must be 16");
   end

   // ----------------------------------------
   // decode functions
   // ----------------------------------------

   // base mode from the opcode row
   function automatic amd_mode_t base_mode(input logic [7:0] op);
      amd_mode_t m;
      m = AMD_M_INH;
      case (op[7:4])
         `AMD_ROW_BIT_REL: m = AMD_M_BIT_D_REL;
         `AMD_ROW_BIT: m = AMD_M_BIT_D;
         `AMD_ROW_REL: m = AMD_M_REL_D;
         // memory read-modify-write rows only map to short or no-offset forms
         `AMD_ROW_RMW_DIR: m = AMD_M_DIR_S;
         `AMD_ROW_RMW_IDX_S: m = AMD_M_IDX_S;
         `AMD_ROW_RMW_IDX_N: m = AMD_M_IDX_N;
         `AMD_ROW_IMM: m = AMD_M_IMM;
         `AMD_ROW_DIR_S: m = AMD_M_DIR_S;
         `AMD_ROW_DIR_L: m = AMD_M_DIR_L;
         `AMD_ROW_IDX_L: m = AMD_M_IDX_L;
         `AMD_ROW_IDX_S: m = AMD_M_IDX_S;
         `AMD_ROW_IDX_N: m = AMD_M_IDX_N;
         default: m = AMD_M_INH;
      endcase
      return m;
   endfunction : base_mode

   // prefix rewrites the mode or the index choice
   function automatic logic [6:0] with_prefix(input amd_mode_t m, input amd_prefix_t p);
      amd_mode_t r;
      logic y;
      logic bad;
      r = m;
      y = 1'b0;
      bad = 1'b0;
      case (p)
         AMD_PX_NONE: begin
            r = m;
         end
         AMD_PX_SEC: begin
            y = 1'b1;
            bad = (m inside {AMD_M_REL_D, AMD_M_BIT_D, AMD_M_BIT_D_REL});
         end
         AMD_PX_IND: begin
            case (m)
               AMD_M_DIR_S: r = AMD_M_IND_S;
               AMD_M_DIR_L: r = AMD_M_IND_L;
               AMD_M_IDX_S: r = AMD_M_IND_IDX_S;
               AMD_M_IDX_L: r = AMD_M_IND_IDX_L;
               AMD_M_REL_D: r = AMD_M_REL_I;
               AMD_M_BIT_D: r = AMD_M_BIT_I;
               AMD_M_BIT_D_REL: r = AMD_M_BIT_I_REL;
               default: bad = 1'b1;
            endcase
         end
         AMD_PX_IND_SEC: begin
            y = 1'b1;
            case (m)
               AMD_M_IDX_S: r = AMD_M_IND_IDX_S;
               AMD_M_IDX_L: r = AMD_M_IND_IDX_L;
               default: bad = 1'b1;
            endcase
         end
         default: bad = 1'b1;
      endcase
      return {bad, y, r};
   endfunction : with_prefix

   // bytes after the opcode for each mode
   function automatic logic [1:0] extra_bytes(input amd_mode_t m);
      logic [1:0] n;
      case (m)
         AMD_M_INH, AMD_M_IDX_N: n = 2'h0;
         AMD_M_DIR_L, AMD_M_IDX_L, AMD_M_BIT_D_REL, AMD_M_BIT_I_REL: n = 2'h2;
         default: n = 2'h1;
      endcase
      return n;
   endfunction : extra_bytes

   // pointer size: 0 none, 1 byte, 2 word
   function automatic logic [1:0] ptr_kind(input amd_mode_t m);
      logic [1:0] k;
      case (m)
         AMD_M_IND_S, AMD_M_IND_IDX_S, AMD_M_REL_I, AMD_M_BIT_I, AMD_M_BIT_I_REL: k = 2'h1;
         AMD_M_IND_L, AMD_M_IND_IDX_L: k = 2'h2;
         default: k = 2'h0;
      endcase
      return k;
   endfunction : ptr_kind

   function automatic amd_family_t family_of(input amd_mode_t m);
      amd_family_t f;
      case (m)
         AMD_M_INH: f = AMD_F_INH;
         AMD_M_IMM: f = AMD_F_IMM;
         AMD_M_DIR_S, AMD_M_DIR_L: f = AMD_F_DIR;
         AMD_M_IDX_N, AMD_M_IDX_S, AMD_M_IDX_L: f = AMD_F_IDX;
         AMD_M_IND_S, AMD_M_IND_L, AMD_M_IND_IDX_S, AMD_M_IND_IDX_L: f = AMD_F_IND;
         AMD_M_REL_D, AMD_M_REL_I: f = AMD_F_REL;
         default: f = AMD_F_BIT;
      endcase
      return f;
   endfunction : family_of

   function automatic amd_inh_t inh_of(input logic [7:0] op);
      amd_inh_t i;
      case (op)
         `AMD_OP_NOP: i = AMD_I_NOP;
         `AMD_OP_TRAP: i = AMD_I_TRAP;
         `AMD_OP_WAIT: i = AMD_I_WAIT;
         `AMD_OP_HALT: i = AMD_I_HALT;
         `AMD_OP_RET: i = AMD_I_RET;
         `AMD_OP_IRET: i = AMD_I_IRET;
         `AMD_OP_SET_MASK: i = AMD_I_SET_MASK;
         `AMD_OP_CLR_MASK: i = AMD_I_CLR_MASK;
         `AMD_OP_SET_CARRY: i = AMD_I_SET_CARRY;
         `AMD_OP_CLR_CARRY: i = AMD_I_CLR_CARRY;
         `AMD_OP_SP_RESET: i = AMD_I_SP_RESET;
         `AMD_OP_MUL: i = AMD_I_MUL;
         default: i = AMD_I_OTHER;
      endcase
      return i;
   endfunction : inh_of

   function automatic logic is_prefix(input logic [7:0] b);
      return (b == `AMD_PFX_SEC_INDEX) || (b == `AMD_PFX_SEC_INDIRECT) ||
             (b == `AMD_PFX_INDIRECT);
   endfunction : is_prefix

   // ----------------------------------------
   // state and address adder
   // ----------------------------------------
   amd_seq_t s_q;
   amd_seq_t s_d;
   logic [15:0] base;
   logic [7:0] rel;
   logic [7:0] index;
   logic [15:0] ea;
   logic [15:0] target;
   logic [6:0] dec;
   logic [15:0] pc_inc;
   logic [2:0] len_inc;

   assign pc_inc = s_q.pc + 16'h0001;
   assign len_inc = s_q.len + 3'h1;
   assign index = s_q.use_y ? s_q.idx_y : s_q.idx_x;
   assign dec = with_prefix(base_mode(i_mem_rdata), s_q.pfx);

   // operand base: pointer value, address word, or a page-zero byte
   always_comb begin
      base = {`AMD_PAGE0_HI, s_q.arg[7:0]};
      rel = s_q.arg[7:0];
      if (ptr_kind(s_q.mode) != 2'h0) begin
         base = s_q.ptr;
      end else if (s_q.mode inside {AMD_M_DIR_L, AMD_M_IDX_L}) begin
         base = s_q.arg;
      end else if (s_q.mode == AMD_M_BIT_D_REL) begin
         // bit address stays in page zero
         base = {`AMD_PAGE0_HI, s_q.arg[15:8]};
      end
      if (s_q.mode == AMD_M_REL_I) begin
         rel = s_q.ptr[7:0];
      end
   end

   amd_ea_calc u_ea (
      .i_mode(s_q.mode),
      .i_base(base),
      .i_index(index),
      .i_rel(rel),
      .i_next_pc(s_q.pc),
      .o_ea(ea),
      .o_target(target)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------

   // memory request is a level held until acknowledged
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         AMD_S_IDLE: begin
            if (i_start) begin
               s_d.st = AMD_S_OPC;
               s_d.pc = i_pc;
               s_d.mem_addr = i_pc;
               s_d.pfx = AMD_PX_NONE;
               s_d.illegal = 1'b0;
               s_d.len = 3'h0;
               s_d.arg = 16'h0000;
               s_d.ptr = 16'h0000;
               s_d.idx_x = i_x;
               s_d.idx_y = i_y;
            end
         end
         AMD_S_OPC: begin
            if (i_mem_ack) begin
               s_d.pc = pc_inc;
               s_d.mem_addr = pc_inc;
               s_d.len = len_inc;
               if (is_prefix(i_mem_rdata) && s_q.pfx == AMD_PX_NONE) begin
                  // secondary index prefix costs one byte
                  case (i_mem_rdata)
                     `AMD_PFX_SEC_INDEX: s_d.pfx = AMD_PX_SEC;
                     `AMD_PFX_INDIRECT: s_d.pfx = AMD_PX_IND;
                     default: s_d.pfx = AMD_PX_IND_SEC;
                  endcase
               end else begin
                  // a second prefix or a bad pairing ends the decode as illegal
                  s_d.opcode = i_mem_rdata;
                  s_d.illegal = dec[6] | is_prefix(i_mem_rdata);
                  s_d.use_y = dec[5];
                  s_d.mode = amd_mode_t'(dec[4:0]);
                  s_d.cnt = extra_bytes(amd_mode_t'(dec[4:0]));
                  if (s_d.illegal || s_d.cnt == 2'h0) begin
                     s_d.st = AMD_S_FIN;
                  end else begin
                     s_d.st = AMD_S_ARG;
                  end
               end
            end
         end
         AMD_S_ARG: begin
            if (i_mem_ack) begin
               // bytes shift in high byte first
               s_d.arg = {s_q.arg[7:0], i_mem_rdata};
               s_d.pc = pc_inc;
               s_d.mem_addr = pc_inc;
               s_d.len = len_inc;
               s_d.cnt = s_q.cnt - 2'h1;
               if (s_q.cnt == 2'h1) begin
                  s_d.st = AMD_S_FIN;
                  if (ptr_kind(s_q.mode) != 2'h0) begin
                     s_d.st = AMD_S_PTR_H;
                     s_d.mem_addr = {`AMD_PAGE0_HI,
                        (s_q.mode == AMD_M_BIT_I_REL) ? s_q.arg[7:0] : i_mem_rdata};
                  end
               end
            end
         end
         AMD_S_PTR_H: begin
            if (i_mem_ack) begin
               if (ptr_kind(s_q.mode) == 2'h2) begin
                  s_d.ptr = {i_mem_rdata, 8'h00};
                  s_d.mem_addr = {`AMD_PAGE0_HI, s_q.mem_addr[7:0] + 8'h01};
                  s_d.st = AMD_S_PTR_L;
               end else begin
                  // byte pointer is the operand address
                  s_d.ptr = {`AMD_PAGE0_HI, i_mem_rdata};
                  s_d.st = AMD_S_FIN;
               end
            end
         end
         AMD_S_PTR_L: begin
            if (i_mem_ack) begin
               s_d.ptr = {s_q.ptr[15:8], i_mem_rdata};
               s_d.st = AMD_S_FIN;
            end
         end
         AMD_S_FIN: begin
            // all three indexed variants resolved by the adder
            s_d.res.ea = ea;
            s_d.res.target = target;
            s_d.res.next_pc = s_q.pc;
            s_d.res.opcode = s_q.opcode;
            s_d.res.operand = s_q.arg[7:0];
            s_d.res.mode = s_q.mode;
            s_d.res.family = family_of(s_q.mode);
            s_d.res.inh = (s_q.mode == AMD_M_INH) ? inh_of(s_q.opcode) : AMD_I_NONE;
            s_d.res.length = s_q.len;
            s_d.res.use_y = s_q.use_y;
            s_d.res.rmw = s_q.opcode[7:4] inside {`AMD_ROW_BIT_REL, `AMD_ROW_BIT,
               `AMD_ROW_RMW_DIR, `AMD_ROW_RMW_IDX_S, `AMD_ROW_RMW_IDX_N};
            s_d.res.bit_pos = s_q.opcode[3:1];
            s_d.res.bit_clr = s_q.opcode[0];
            s_d.res.illegal = s_q.illegal;
            s_d.done = 1'b1;
            s_d.st = AMD_S_IDLE;
         end
         default: begin
            s_d.st = AMD_S_IDLE;
         end
      endcase
   end

   // single register for the whole state
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         s_q <= `AMD_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_mem_req = s_q.st inside {AMD_S_OPC, AMD_S_ARG, AMD_S_PTR_H, AMD_S_PTR_L};
   assign o_mem_addr = s_q.mem_addr;
   assign o_busy = (s_q.st != AMD_S_IDLE);
   assign o_done = s_q.done;
   assign o_result = s_q.res;

endmodule : amd_decoder

//--- verilog/amd_ea_calc.sv
// effective address and branch target adder
`timescale 1ns/100ps
`include "amd_params.svh"

module amd_ea_calc (
   // operand sources
   input wire amd_pkg::amd_mode_t i_mode,
   input wire logic [15:0] i_base,
   input wire logic [7:0] i_index,
   input wire logic [7:0] i_rel,
   input wire logic [15:0] i_next_pc,
   // results
   output logic [15:0] o_ea,
   output logic [15:0] o_target
);
   import amd_pkg::*;

   logic [15:0] idx_sum;
   logic [15:0] rel_sum;

   assign idx_sum = i_base + {`AMD_PAGE0_HI, i_index};
   assign rel_sum = i_next_pc + {{8{i_rel[7]}}, i_rel};

   // pick the address per mode; long indexed wraps inside the 64 Kbyte space
   always_comb begin
      o_ea = i_base;
      o_target = i_next_pc;
      case (i_mode)
         AMD_M_INH, AMD_M_IMM: begin
            o_ea = 16'h0000;
         end
         // no offset stays in 00 to FF
         AMD_M_IDX_N: begin
            o_ea = {`AMD_PAGE0_HI, i_index};
         end
         // byte offset or byte pointer plus index reaches 1FE; word offset or word pointer plus index wraps past FFFF
         AMD_M_IDX_S, AMD_M_IDX_L, AMD_M_IND_IDX_S, AMD_M_IND_IDX_L: begin
            o_ea = idx_sum;
         end
         AMD_M_REL_D, AMD_M_REL_I: begin
            o_ea = rel_sum;
            o_target = rel_sum;
         end
         AMD_M_BIT_D_REL, AMD_M_BIT_I_REL: begin
            o_target = rel_sum;
         end
         default: begin
            o_ea = i_base;
         end
      endcase
   end

endmodule : amd_ea_calc

//--- verilog/amd_params.svh
// constants for the addressing-mode decoder: prefixes, opcode rows, sizes, reset values
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH

// ----------------------------------------
// address space
// ----------------------------------------
`define AMD_ADDR_W 16
`define AMD_PAGE0_HI 8'h00

// ----------------------------------------
// prefix opcodes
// ----------------------------------------
`define AMD_PFX_SEC_INDEX 8'h90
`define AMD_PFX_SEC_INDIRECT 8'h91
`define AMD_PFX_INDIRECT 8'h92

// ----------------------------------------
// opcode rows (high nibble)
// ----------------------------------------
`define AMD_ROW_BIT_REL 4'h0
`define AMD_ROW_BIT 4'h1
`define AMD_ROW_REL 4'h2
`define AMD_ROW_RMW_DIR 4'h3
`define AMD_ROW_RMW_ACC 4'h4
`define AMD_ROW_RMW_IDXREG 4'h5
`define AMD_ROW_RMW_IDX_S 4'h6
`define AMD_ROW_RMW_IDX_N 4'h7
`define AMD_ROW_CTRL_A 4'h8
`define AMD_ROW_CTRL_B 4'h9
`define AMD_ROW_IMM 4'ha
`define AMD_ROW_DIR_S 4'hb
`define AMD_ROW_DIR_L 4'hc
`define AMD_ROW_IDX_L 4'hd
`define AMD_ROW_IDX_S 4'he
`define AMD_ROW_IDX_N 4'hf

// ----------------------------------------
// inherent control opcodes
// ----------------------------------------
`define AMD_OP_IRET 8'h80
`define AMD_OP_RET 8'h81
`define AMD_OP_TRAP 8'h83
`define AMD_OP_HALT 8'h8e
`define AMD_OP_WAIT 8'h8f
`define AMD_OP_MUL 8'h42
`define AMD_OP_CLR_CARRY 8'h98
`define AMD_OP_SET_CARRY 8'h99
`define AMD_OP_CLR_MASK 8'h9a
`define AMD_OP_SET_MASK 8'h9b
`define AMD_OP_SP_RESET 8'h9c
`define AMD_OP_NOP 8'h9d

// ----------------------------------------
// reset values
// ----------------------------------------
`define AMD_STATE_RST '0

`endif

//--- verilog/amd_pkg.sv
// types shared by the addressing-mode decoder and its address adder
package amd_pkg;

   // seventeen operand addressing modes
   typedef enum logic [4:0] {
      AMD_M_INH = 5'h00, AMD_M_IMM = 5'h01, AMD_M_DIR_S = 5'h02, AMD_M_DIR_L = 5'h03,
      AMD_M_IDX_N = 5'h04, AMD_M_IDX_S = 5'h05, AMD_M_IDX_L = 5'h06,
      AMD_M_IND_S = 5'h07, AMD_M_IND_L = 5'h08, AMD_M_IND_IDX_S = 5'h09,
      AMD_M_IND_IDX_L = 5'h0a, AMD_M_REL_D = 5'h0b, AMD_M_REL_I = 5'h0c,
      AMD_M_BIT_D = 5'h0d, AMD_M_BIT_I = 5'h0e, AMD_M_BIT_D_REL = 5'h0f,
      AMD_M_BIT_I_REL = 5'h10
   } amd_mode_t;

   // seven mode families
   typedef enum logic [2:0] {
      AMD_F_INH = 3'h0, AMD_F_IMM = 3'h1, AMD_F_DIR = 3'h2, AMD_F_IDX = 3'h3,
      AMD_F_IND = 3'h4, AMD_F_REL = 3'h5, AMD_F_BIT = 3'h6
   } amd_family_t;

   typedef enum logic [1:0] {
      AMD_PX_NONE = 2'h0, AMD_PX_SEC = 2'h1, AMD_PX_IND = 2'h2, AMD_PX_IND_SEC = 2'h3
   } amd_prefix_t;

   // inherent control operations
   typedef enum logic [3:0] {
      AMD_I_NONE = 4'h0, AMD_I_NOP = 4'h1, AMD_I_TRAP = 4'h2, AMD_I_WAIT = 4'h3,
      AMD_I_HALT = 4'h4, AMD_I_RET = 4'h5, AMD_I_IRET = 4'h6, AMD_I_SET_MASK = 4'h7,
      AMD_I_CLR_MASK = 4'h8, AMD_I_SET_CARRY = 4'h9, AMD_I_CLR_CARRY = 4'ha,
      AMD_I_SP_RESET = 4'hb, AMD_I_MUL = 4'hc, AMD_I_OTHER = 4'hd
   } amd_inh_t;

   typedef enum logic [2:0] {
      AMD_S_IDLE = 3'h0, AMD_S_OPC = 3'h1, AMD_S_ARG = 3'h2, AMD_S_PTR_H = 3'h3,
      AMD_S_PTR_L = 3'h4, AMD_S_FIN = 3'h5
   } amd_state_t;

   // decoded result handed to the execution stage
   typedef struct packed {
      logic [15:0] ea;
      logic [15:0] target;
      logic [15:0] next_pc;
      logic [7:0] opcode;
      logic [7:0] operand;
      amd_mode_t mode;
      amd_family_t family;
      amd_inh_t inh;
      logic [2:0] length;
      logic use_y;
      logic rmw;
      logic [2:0] bit_pos;
      logic bit_clr;
      logic illegal;
   } amd_result_t;

   // whole sequencer state
   typedef struct packed {
      amd_state_t st;
      logic [15:0] pc;
      logic [15:0] mem_addr;
      amd_prefix_t pfx;
      amd_mode_t mode;
      logic use_y;
      logic illegal;
      logic [7:0] opcode;
      logic [15:0] arg;
      logic [15:0] ptr;
      logic [1:0] cnt;
      logic [2:0] len;
      logic [7:0] idx_x;
      logic [7:0] idx_y;
      logic done;
      amd_result_t res;
   } amd_seq_t;

endpackage : amd_pkg
